// ===== src/dual_tap_cfg.svh
`ifndef DUAL_TAP_CFG_SVH
`define DUAL_TAP_CFG_SVH
`define TAP_IR_WIDTH      4
`define TAP_IR_IDCODE     4'h1
`define TAP_IR_BYPASS     4'hf
`define TAP_IR_CAPTURE    4'h1
`define TAP_ID_WIDTH      32
`define TAP_MAPPER_IDCODE 32'h0000_1001
`define TAP_XCVR_IDCODE   32'h0000_2001
`define TAP_CLK_HALF_DIV  8
`endif

// ===== src/dual_tap_device.sv
`include "dual_tap_cfg.svh"
module dual_tap_device (
  // System
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Test ports
  dual_tap_if.device tap,
  // Section status
  output logic      mapper_test_mode_o,
  output logic      xcvr_test_mode_o
);
  import dual_tap_pkg::*;
  logic [1:0] tck_raw;
  logic [1:0] tdi_raw;
  logic [1:0] tms_raw;
  logic [1:0] trst_raw;
  logic [1:0] tdo_w;
  logic [1:0] oe_w;
  logic [1:0] mode_w;
  assign tck_raw  = {tap.xcvr_test_clock, tap.mapper_test_clock};
  assign tdi_raw  = {tap.xcvr_test_data_in, tap.mapper_test_data_in};
  assign tms_raw  = {tap.xcvr_test_mode_select, tap.mapper_test_mode_select};
  assign trst_raw = {tap.xcvr_test_reset_n, tap.mapper_test_reset_n};
  assign tap.mapper_test_data_out    = tdo_w[0];
  assign tap.mapper_test_data_out_oe = oe_w[0];
  assign tap.xcvr_test_data_out      = tdo_w[1];
  assign tap.xcvr_test_data_out_oe   = oe_w[1];
  assign mapper_test_mode_o = mode_w[0];
  assign xcvr_test_mode_o   = mode_w[1];

  // Refuse widths the shift paths cannot serve
  if (`TAP_IR_WIDTH < 2) begin : gen_bad_ir
    $error("instruction register must be at least two bits wide");
  end
  if (`TAP_ID_WIDTH != 32) begin : gen_bad_id
    $error("identification register must be 32 bits wide");
  end

  // One controller per section
  for (genvar g = 0; g < 2; g++) begin : gen_port
    localparam logic [`TAP_ID_WIDTH-1:0] ID_VAL = (g == 0) ? `TAP_MAPPER_IDCODE : `TAP_XCVR_IDCODE;
    logic [2:0]                 tck_sync_ff;
    logic [1:0]                 tdi_sync_ff;
    logic [1:0]                 tms_sync_ff;
    logic [1:0]                 trst_sync_ff;
    tap_state_t                 state_ff;
    tap_state_t                 nxt_state;
    logic [`TAP_IR_WIDTH-1:0]   ir_sh_ff;
    logic [`TAP_IR_WIDTH-1:0]   ir_ff;
    logic [`TAP_ID_WIDTH-1:0]   id_sh_ff;
    logic                       byp_ff;
    logic                       tdo_ff;
    logic                       oe_ff;
    logic                       mode_ff;
    logic                       rise;
    logic                       fall;
    logic                       trst_n;

    // Test clock: two synchroniser stages, the third only for edge finding
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        tck_sync_ff <= 3'h0;
      end else begin
        tck_sync_ff <= {tck_sync_ff[1:0], tck_raw[g]};
      end
    end

    // Data, mode select and test reset pins pass two stages before use
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        tdi_sync_ff  <= 2'h0;
        tms_sync_ff  <= 2'h0;
        trst_sync_ff <= 2'h0;
      end else begin
        tdi_sync_ff  <= {tdi_sync_ff[0], tdi_raw[g]};
        tms_sync_ff  <= {tms_sync_ff[0], tms_raw[g]};
        trst_sync_ff <= {trst_sync_ff[0], trst_raw[g]};
      end
    end
    // Edges of the synchronised test clock; test reset from the second stage
    assign rise   = tck_sync_ff[1] & ~tck_sync_ff[2];
    assign fall   = ~tck_sync_ff[1] & tck_sync_ff[2];
    assign trst_n = trst_sync_ff[1];

    // Standard state sequence
    always_comb begin
      nxt_state = state_ff;
      case (state_ff)
        TAP_RESET:    nxt_state = tms_sync_ff[1] ? TAP_RESET : TAP_IDLE;
        TAP_IDLE:     nxt_state = tms_sync_ff[1] ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_DR:   nxt_state = tms_sync_ff[1] ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR:   nxt_state = tms_sync_ff[1] ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_SHIFT_DR: nxt_state = tms_sync_ff[1] ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_EXIT1_DR: nxt_state = tms_sync_ff[1] ? TAP_UPD_DR : TAP_PAUSE_DR;
        TAP_PAUSE_DR: nxt_state = tms_sync_ff[1] ? TAP_EXIT2_DR : TAP_PAUSE_DR;
        TAP_EXIT2_DR: nxt_state = tms_sync_ff[1] ? TAP_UPD_DR : TAP_SHIFT_DR;
        TAP_UPD_DR:   nxt_state = tms_sync_ff[1] ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_IR:   nxt_state = tms_sync_ff[1] ? TAP_RESET : TAP_CAP_IR;
        TAP_CAP_IR:   nxt_state = tms_sync_ff[1] ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_SHIFT_IR: nxt_state = tms_sync_ff[1] ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_EXIT1_IR: nxt_state = tms_sync_ff[1] ? TAP_UPD_IR : TAP_PAUSE_IR;
        TAP_PAUSE_IR: nxt_state = tms_sync_ff[1] ? TAP_EXIT2_IR : TAP_PAUSE_IR;
        TAP_EXIT2_IR: nxt_state = tms_sync_ff[1] ? TAP_UPD_IR : TAP_SHIFT_IR;
        TAP_UPD_IR:   nxt_state = tms_sync_ff[1] ? TAP_SEL_DR : TAP_IDLE;
        default:      nxt_state = TAP_RESET;
      endcase
    end

    // State register, forced to reset whenever test reset is low.
    // The test reset acts through its synchroniser, so it needs no test clock but
    // takes effect three system clocks after the pin falls.
    always_ff @(posedge clk_i) begin
      if (!rst_n_i || !trst_n) begin
        state_ff <= TAP_RESET;
      end else if (rise) begin
        state_ff <= nxt_state;
      end
    end

    // Instruction path; reset loads the identification instruction
    always_ff @(posedge clk_i) begin
      if (!rst_n_i || !trst_n) begin
        ir_sh_ff <= `TAP_IR_CAPTURE;
        ir_ff    <= `TAP_IR_IDCODE;
      end else if (rise) begin
        case (state_ff)
          TAP_RESET:    ir_ff    <= `TAP_IR_IDCODE;
          TAP_CAP_IR:   ir_sh_ff <= `TAP_IR_CAPTURE;
          TAP_SHIFT_IR: ir_sh_ff <= {tdi_sync_ff[1], ir_sh_ff[`TAP_IR_WIDTH-1:1]};
          TAP_UPD_IR:   ir_ff    <= ir_sh_ff;
          default:      ir_sh_ff <= ir_sh_ff;
        endcase
      end
    end

    // Identification register: loads the section's code on capture, shifts toward the output
    always_ff @(posedge clk_i) begin
      if (!rst_n_i || !trst_n) begin
        id_sh_ff <= '0;
      end else if (rise) begin
        if (state_ff == TAP_CAP_DR) begin
          id_sh_ff <= ID_VAL;
        end else if (state_ff == TAP_SHIFT_DR) begin
          id_sh_ff <= {tdi_sync_ff[1], id_sh_ff[`TAP_ID_WIDTH-1:1]};
        end
      end
    end

    // Bypass stage: one bit of delay, cleared on capture
    always_ff @(posedge clk_i) begin
      if (!rst_n_i || !trst_n) begin
        byp_ff <= 1'b0;
      end else if (rise) begin
        if (state_ff == TAP_CAP_DR) begin
          byp_ff <= 1'b0;
        end else if (state_ff == TAP_SHIFT_DR) begin
          byp_ff <= tdi_sync_ff[1];
        end
      end
    end

    // Output enable: high only while a shift state drives the data output
    always_ff @(posedge clk_i) begin
      if (!rst_n_i || !trst_n) begin
        oe_ff <= 1'b0;
      end else if (fall) begin
        oe_ff <= (state_ff == TAP_SHIFT_DR) || (state_ff == TAP_SHIFT_IR);
      end
    end

    // Serial output updates on the falling edge, so the far end samples it at the end of the next high half, a full period later
    always_ff @(posedge clk_i) begin
      if (!rst_n_i || !trst_n) begin
        tdo_ff <= 1'b0;
      end else if (fall) begin
        if (state_ff == TAP_SHIFT_IR) begin
          tdo_ff <= ir_sh_ff[0];
        end else if (ir_ff == `TAP_IR_IDCODE) begin
          tdo_ff <= id_sh_ff[0];
        end else begin
          tdo_ff <= byp_ff;
        end
      end
    end

    // Test mode follows the reset pin level
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        mode_ff <= 1'b0;
      end else begin
        mode_ff <= trst_n;
      end
    end

    assign tdo_w[g]  = tdo_ff;
    assign oe_w[g]   = oe_ff;
    assign mode_w[g] = mode_ff;
  end
endmodule // dual_tap_device

// ===== src/dual_tap_host.sv
`include "dual_tap_cfg.svh"
module dual_tap_host #(
  parameter int HALF_DIV = `TAP_CLK_HALF_DIV
) (
  // System
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Test ports
  dual_tap_if.host         tap,
  // Per-port user controls, index 0 mapper, 1 transceiver
  input  wire logic [1:0]  test_enable_i,
  input  wire logic [1:0]  step_i,
  input  wire logic [1:0]  tms_i,
  input  wire logic [1:0]  tdi_i,
  // Per-port results
  output logic      [1:0]  busy_o,
  output logic      [1:0]  tdo_o,
  output logic      [1:0]  tdo_valid_o
);
  import dual_tap_pkg::*;
  logic [1:0] tck_w;
  logic [1:0] tms_w;
  logic [1:0] tdi_w;
  logic [1:0] trst_w;
  logic [1:0] tdo_raw;
  assign tap.mapper_test_clock       = tck_w[0];
  assign tap.mapper_test_mode_select = tms_w[0];
  assign tap.mapper_test_data_in     = tdi_w[0];
  assign tap.mapper_test_reset_n     = trst_w[0];
  assign tap.xcvr_test_clock         = tck_w[1];
  assign tap.xcvr_test_mode_select   = tms_w[1];
  assign tap.xcvr_test_data_in       = tdi_w[1];
  assign tap.xcvr_test_reset_n       = trst_w[1];
  assign tdo_raw = {tap.xcvr_test_data_out, tap.mapper_test_data_out};

  // Device edge finding needs four clocks per half period; the counter is 16 bits
  if (HALF_DIV < 4 || HALF_DIV > 65536) begin : gen_bad_div
    $error("HALF_DIV must lie between 4 and 65536");
  end

  // One bit-cycle engine per port
  for (genvar g = 0; g < 2; g++) begin : gen_port
    logic [15:0] cnt_ff;
    logic        phase_ff;
    logic        tck_ff;
    logic        tms_ff;
    logic        tdi_ff;
    logic        trst_ff;
    logic [1:0]  tdo_sync_ff;
    logic        tdo_ff;
    logic        vld_ff;
    logic        tick;
    assign tick = (cnt_ff == 16'(HALF_DIV - 1));

    // Reset pin low unless test is enabled; raising it enters test mode
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        trst_ff <= 1'b0;
      end else begin
        trst_ff <= test_enable_i[g];
      end
    end

    // Divider makes one test clock period per step
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        cnt_ff   <= 16'h0;
        phase_ff <= 1'b0;
        tck_ff   <= 1'b0;
        tms_ff   <= 1'b1;
        tdi_ff   <= 1'b1;
      end else if (phase_ff || tck_ff) begin
        cnt_ff <= tick ? 16'h0 : cnt_ff + 16'h1;
        if (tick) begin
          tck_ff   <= ~tck_ff;
          phase_ff <= 1'b0;
        end
      end else if (step_i[g] && trst_ff) begin
        tms_ff   <= tms_i[g];
        tdi_ff   <= tdi_i[g];
        phase_ff <= 1'b1;
        cnt_ff   <= 16'h0;
      end
    end

    // Sample returned data at the end of the high half, well after the device's last update
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        tdo_sync_ff <= 2'h0;
        tdo_ff      <= 1'b0;
        vld_ff      <= 1'b0;
      end else begin
        tdo_sync_ff <= {tdo_sync_ff[0], tdo_raw[g]};
        vld_ff      <= 1'b0;
        if (tck_ff && tick) begin
          tdo_ff <= tdo_sync_ff[1];
          vld_ff <= 1'b1;
        end
      end
    end

    assign tck_w[g]       = tck_ff;
    assign tms_w[g]       = tms_ff;
    assign tdi_w[g]       = tdi_ff;
    assign trst_w[g]      = trst_ff;
    assign busy_o[g]      = phase_ff | tck_ff;
    assign tdo_o[g]       = tdo_ff;
    assign tdo_valid_o[g] = vld_ff;
  end
endmodule // dual_tap_host

// ===== src/dual_tap_if.sv
interface dual_tap_if;
  logic mapper_test_clock;
  logic mapper_test_data_in;
  logic mapper_test_data_out;
  logic mapper_test_data_out_oe;
  logic mapper_test_mode_select;
  logic mapper_test_reset_n;
  logic xcvr_test_clock;
  logic xcvr_test_data_in;
  logic xcvr_test_data_out;
  logic xcvr_test_data_out_oe;
  logic xcvr_test_mode_select;
  logic xcvr_test_reset_n;
  modport device (
    input  mapper_test_clock, mapper_test_data_in, mapper_test_mode_select, mapper_test_reset_n,
    input  xcvr_test_clock, xcvr_test_data_in, xcvr_test_mode_select, xcvr_test_reset_n,
    output mapper_test_data_out, mapper_test_data_out_oe, xcvr_test_data_out, xcvr_test_data_out_oe
  );
  modport host (
    output mapper_test_clock, mapper_test_data_in, mapper_test_mode_select, mapper_test_reset_n,
    output xcvr_test_clock, xcvr_test_data_in, xcvr_test_mode_select, xcvr_test_reset_n,
    input  mapper_test_data_out, mapper_test_data_out_oe, xcvr_test_data_out, xcvr_test_data_out_oe
  );
endinterface

// ===== src/dual_tap_pkg.sv
package dual_tap_pkg;
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR,
    TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_t;
endpackage

// ===== test/dual_tap_monitor.sv
module dual_tap_monitor (
  // System
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Mapper port
  input wire logic mapper_test_clock,
  input wire logic mapper_test_data_in,
  input wire logic mapper_test_data_out,
  input wire logic mapper_test_data_out_oe,
  input wire logic mapper_test_mode_select,
  input wire logic mapper_test_reset_n,
  // Transceiver port
  input wire logic xcvr_test_clock,
  input wire logic xcvr_test_data_in,
  input wire logic xcvr_test_data_out,
  input wire logic xcvr_test_data_out_oe,
  input wire logic xcvr_test_mode_select,
  input wire logic xcvr_test_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Test reset held long enough to pass the synchroniser
  sequence s_mapper_held_reset;
    (!mapper_test_reset_n) [*5];
  endsequence
  sequence s_xcvr_held_reset;
    (!xcvr_test_reset_n) [*5];
  endsequence

  // Output bit only moves in the low half of the test clock
  a_mapper_tdo_fall: assert property (
    $changed(mapper_test_data_out) |-> !mapper_test_clock && !$past(mapper_test_clock))
    else $error("mapper output bit moved while test clock high");
  a_xcvr_tdo_fall: assert property (
    $changed(xcvr_test_data_out) |-> !xcvr_test_clock && !$past(xcvr_test_clock))
    else $error("xcvr output bit moved while test clock high");
  // Held test reset keeps the controller out of shift states
  a_mapper_reset_quiet: assert property (s_mapper_held_reset |-> !mapper_test_data_out_oe)
    else $error("mapper output enabled under test reset");
  a_xcvr_reset_quiet: assert property (s_xcvr_held_reset |-> !xcvr_test_data_out_oe)
    else $error("xcvr output enabled under test reset");
  // Shift entry and exit follow the sampled mode select
  a_mapper_shift_entry: assert property ($rose(mapper_test_data_out_oe) |-> !mapper_test_mode_select)
    else $error("mapper entered shift with mode select high");
  a_mapper_shift_exit: assert property ($fell(mapper_test_data_out_oe) && mapper_test_reset_n |-> mapper_test_mode_select)
    else $error("mapper left shift with mode select low");
  a_xcvr_shift_entry: assert property ($rose(xcvr_test_data_out_oe) |-> !xcvr_test_mode_select)
    else $error("xcvr entered shift with mode select high");
  a_xcvr_shift_exit: assert property ($fell(xcvr_test_data_out_oe) && xcvr_test_reset_n |-> xcvr_test_mode_select)
    else $error("xcvr left shift with mode select low");
endmodule // dual_tap_monitor

// ===== test/tb_top.sv
`include "dual_tap_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct { int port; logic [31:0] id; } row_t;
  logic       clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [1:0] test_enable_i = 2'h0;
  logic [1:0] step_i = 2'h0;
  logic [1:0] tms_i = 2'h3;
  logic [1:0] tdi_i = 2'h3;
  logic [1:0] busy_o, tdo_o, tdo_valid_o, mode_w;
  logic       mapper_test_mode_o, xcvr_test_mode_o;
  logic [31:0] v0, v1;
  logic [3:0]  ir_seen;
  logic [7:0]  byp_seen;
  int         num_errors = 0;
  int         checks_done = 0;
  row_t       rows [2] = '{'{0, `TAP_MAPPER_IDCODE}, '{1, `TAP_XCVR_IDCODE}};

  // Both ends joined across one interface
  dual_tap_if tap_if ();
  dual_tap_device dual_tap_device_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .tap(tap_if.device),
    .mapper_test_mode_o(mapper_test_mode_o), .xcvr_test_mode_o(xcvr_test_mode_o));
  dual_tap_host #(.HALF_DIV(4)) dual_tap_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .tap(tap_if.host),
    .test_enable_i(test_enable_i), .step_i(step_i), .tms_i(tms_i), .tdi_i(tdi_i),
    .busy_o(busy_o), .tdo_o(tdo_o), .tdo_valid_o(tdo_valid_o));
  dual_tap_monitor dual_tap_monitor_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .mapper_test_clock(tap_if.mapper_test_clock), .mapper_test_data_in(tap_if.mapper_test_data_in),
    .mapper_test_data_out(tap_if.mapper_test_data_out), .mapper_test_data_out_oe(tap_if.mapper_test_data_out_oe),
    .mapper_test_mode_select(tap_if.mapper_test_mode_select), .mapper_test_reset_n(tap_if.mapper_test_reset_n),
    .xcvr_test_clock(tap_if.xcvr_test_clock), .xcvr_test_data_in(tap_if.xcvr_test_data_in),
    .xcvr_test_data_out(tap_if.xcvr_test_data_out), .xcvr_test_data_out_oe(tap_if.xcvr_test_data_out_oe),
    .xcvr_test_mode_select(tap_if.xcvr_test_mode_select), .xcvr_test_reset_n(tap_if.xcvr_test_reset_n));

  // Clock and section status per port
  always #4 clk_i = ~clk_i;
  assign mode_w = {xcvr_test_mode_o, mapper_test_mode_o};

  // Compare and count
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("[FAIL] %s exp %h got %h", what, exp, got);
      num_errors++;
    end
  endtask

  // Verdict and end of run
  task test_done;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One test clock period; returns the bit seen before the falling edge
  task automatic step(input int p, input logic tms, output logic bit_o, input logic tdi = 1'b0);
    int n;
    n = 0;
    step_i[p] <= 1'b1;
    tms_i[p] <= tms;
    tdi_i[p] <= tdi;
    @(posedge clk_i);
    step_i[p] <= 1'b0;
    while (tdo_valid_o[p] !== 1'b1 && n < 100) begin @(posedge clk_i); n++; end
    bit_o = tdo_o[p];
    while (busy_o[p] !== 1'b0 && n < 100) begin @(posedge clk_i); n++; end
    if (n >= 100) begin $display("[FAIL] step_done exp 1 got 0"); num_errors++; end
  endtask

  // From reset state walk to shift-DR and read stop bits, LSB first
  task automatic read_id(int p, int stop, output logic [31:0] v);
    logic b;
    v = 32'h0;
    step(p, 1'b0, b);
    step(p, 1'b1, b);
    step(p, 1'b0, b);
    step(p, 1'b0, b);
    for (int i = 0; i < stop; i++) begin step(p, i == 31, b); v[i] = b; end
    if (stop == 32) begin step(p, 1'b1, b); step(p, 1'b0, b); end
  endtask

  // From reset state load the bypass instruction, then shift a pattern through it
  task automatic ir_bypass(int p, output logic [3:0] ir_v, output logic [7:0] dr_v);
    logic       b;
    logic [7:0] pat;
    pat = 8'hb4;
    step(p, 1'b0, b);
    step(p, 1'b1, b);
    step(p, 1'b1, b);
    step(p, 1'b0, b);
    step(p, 1'b0, b);
    for (int i = 0; i < 4; i++) begin step(p, i == 3, b, 1'b1); ir_v[i] = b; end
    step(p, 1'b1, b);
    step(p, 1'b0, b);
    step(p, 1'b1, b);
    step(p, 1'b0, b);
    step(p, 1'b0, b);
    for (int i = 0; i < 8; i++) begin step(p, i == 7, b, pat[i]); dr_v[i] = b; end
    step(p, 1'b1, b);
    step(p, 1'b0, b);
  endtask

  task automatic enable(int p, logic v);
    test_enable_i[p] <= v;
    repeat (8) @(posedge clk_i);
  endtask

  // Hang guard
  initial begin
    #200000;
    $display("[FAIL] watchdog exp done got timeout");
    num_errors++;
    test_done();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    foreach (rows[k]) begin
      check("mode_idle", 32'h0, 32'(mode_w[rows[k].port]));
      enable(rows[k].port, 1'b1);
      check("mode_test", 32'h1, 32'(mode_w[rows[k].port]));
      read_id(rows[k].port, 32, v0);
      check("idcode", rows[k].id, v0);
      enable(rows[k].port, 1'b0);
      check("mode_normal", 32'h0, 32'(mode_w[rows[k].port]));
      $display("row %0d done", k);
    end
    // Step refused while the test reset is low
    step_i[0] <= 1'b1;
    @(posedge clk_i);
    step_i[0] <= 1'b0;
    repeat (3) @(posedge clk_i);
    check("busy_refused", 32'h0, 32'(busy_o));
    $display("refusal test done");
    // Instruction path: capture pattern shifted out, bypass delays data by one stage
    enable(0, 1'b1);
    ir_bypass(0, ir_seen, byp_seen);
    check("ir_capture", 32'(`TAP_IR_CAPTURE), 32'(ir_seen));
    check("bypass_delay", 32'h0000_0068, 32'(byp_seen));
    enable(0, 1'b0);
    $display("instruction test done");
    // Reset in mid-shift, then both ports read at once
    enable(1, 1'b1);
    read_id(1, 10, v1);
    check("idcode_part", `TAP_XCVR_IDCODE & 32'h0000_03ff, v1);
    enable(1, 1'b0);
    enable(1, 1'b1);
    enable(0, 1'b1);
    fork
      read_id(0, 32, v0);
      read_id(1, 32, v1);
    join
    check("idcode_mapper", `TAP_MAPPER_IDCODE, v0);
    check("idcode_xcvr", `TAP_XCVR_IDCODE, v1);
    $display("abort test done");
    test_done();
  end
endmodule // tb_top
